// ---- design/reset_init_pkg.sv ----
// Overview of operation
// - six sources ranked: alternate pin, host reset, isolation, D3-D0, software, selective reset
// - eeprom load on alternate, host, isolation; phy reset on alternate, host
// - microcode and statistics cleared by alternate, host, D3-D0, software
// - mac config and hash cleared by every source but selective reset
// - memory pointers and micromachine reset by all sources except isolation
// - pci config cleared by alternate, host, isolation and D3-D0 only
// - pm event state: alternate always, host only without aux power
// - alternate, host, isolation end mgmt command; status and receive off
// - D3-D0 aborts mgmt cycle, zero reads, ignored writes, status inactive
// - after D3-D0 raise mgmt alert and initialization status bit
// - software/selective abort cycle, status kept; software also signals init
// - isolation acts on its trailing edge, not while held
// - in D3 the host reset acts on its trailing edge
// - host side resets accepted while a mgmt transaction runs
package reset_init_pkg;
	localparam int DOM_N = 8;
	localparam int DOM_EEPROM = 0;
	localparam int DOM_UCODE = 1;
	localparam int DOM_MAC = 2;
	localparam int DOM_MEMPTR = 3;
	localparam int DOM_PCICFG = 4;
	localparam int DOM_PHY = 5;
	localparam int DOM_PMEVT = 6;
	localparam int DOM_STAT = 7;
	// effect of each source on the domains
	localparam logic [7:0] EFF_ALT = 8'hFF;
	localparam logic [7:0] EFF_HOST = 8'hFF;
	localparam logic [7:0] EFF_ISO = 8'h15;
	localparam logic [7:0] EFF_D3D0 = 8'h9E;
	localparam logic [7:0] EFF_SW = 8'h8E;
	localparam logic [7:0] EFF_SEL = 8'h08;
	localparam logic [7:0] EFF_NONE = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [1:0] SYNC_RST = 2'h3;
endpackage : reset_init_pkg

// ---- design/reset_init_distributor.sv ----
`timescale 1ns/1ps
module reset_init_distributor
	import reset_init_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// asynchronous pins
	input  wire logic       alternate_reset_n,
	input  wire logic       hostBusReset_n,
	input  wire logic       bus_isolation_n,
	input  wire logic       auxPowerPresent,
	// same-clock power and command events
	input  wire logic       pmInD3,
	input  wire logic       d3ToD0,
	input  wire logic       swResetCmd,
	input  wire logic       selResetCmd,
	// management bus side
	input  wire logic       mgmtCycleActive,
	input  wire logic       mgmtCycleRead,
	input  wire logic [7:0] mgmtRawData,
	input  wire logic       mgmtStatusSetReq,
	input  wire logic       mgmtRxEnableReq,
	input  wire logic       mgmtAlertAck,
	output logic [7:0]      mgmtReadData,
	output logic            mgmtWriteIgnore,
	output logic            mgmtTerminate,
	output logic            mgmtAbort,
	output logic            mgmtStatusActive,
	output logic            mgmtRxEnable,
	output logic            initStatusBit,
	output logic            mgmt_bus_alert_n_o,
	output logic            mgmt_bus_alert_n_oe,
	// domain resets
	output logic            eepromLoadStart,
	output logic            ucodeReset,
	output logic            macCfgReset,
	output logic            memPtrReset,
	output logic            pciCfgReset,
	output logic            phyCfgReset,
	output logic            pmEventReset,
	output logic            statCntReset
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] altSync;
	logic [1:0] hostSync;
	logic [1:0] isoSync;
	logic [1:0] auxSync;
	logic       hostPrev;
	logic       isoPrev;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			altSync  <= SYNC_RST;
			hostSync <= SYNC_RST;
			isoSync  <= SYNC_RST;
			auxSync  <= 2'h0;
			hostPrev <= 1'b1;
			isoPrev  <= 1'b1;
		end else begin
			altSync  <= {altSync[0], alternate_reset_n};
			hostSync <= {hostSync[0], hostBusReset_n};
			isoSync  <= {isoSync[0], bus_isolation_n};
			auxSync  <= {auxSync[0], auxPowerPresent};
			hostPrev <= hostSync[1];
			isoPrev  <= isoSync[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source decode

	wire altEv    = !altSync[1];
	wire hostLow  = !hostSync[1];
	wire hostRise = hostSync[1] && !hostPrev;
	// in D3 the host reset counts only as it is released
	wire hostEv   = pmInD3 ? hostRise : hostLow;
	wire isoEv    = isoSync[1] && !isoPrev;
	wire fullEv   = altEv || hostEv || isoEv;
	wire abortEv  = d3ToD0 || swResetCmd || selResetCmd;
	wire initEv   = d3ToD0 || swResetCmd;

	// host reset spares pm event state when aux power holds it
	wire [7:0] hostEff = auxSync[1] ?
		(EFF_HOST & ~(8'h01 << DOM_PMEVT)) : EFF_HOST;

	// union of all sources; higher masks contain the lower ones, except isolation, which holds none of D3-D0, software, selective
	wire [7:0] next_domRst =
		(altEv ? EFF_ALT : EFF_NONE) |
		(hostEv ? hostEff : EFF_NONE) |
		(isoEv ? EFF_ISO : EFF_NONE) |
		(d3ToD0 ? EFF_D3D0 : EFF_NONE) |
		(swResetCmd ? EFF_SW : EFF_NONE) |
		(selResetCmd ? EFF_SEL : EFF_NONE);

	////////////////////////////////////////////////////////////////////////
	// domain reset register

	logic [7:0] domRst;
	logic       eepromPrev;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			domRst     <= EFF_ALT;
			eepromPrev <= 1'b1;
		end else begin
			domRst     <= next_domRst;
			eepromPrev <= domRst[DOM_EEPROM];
		end
	end

	assign ucodeReset   = domRst[DOM_UCODE];
	assign macCfgReset  = domRst[DOM_MAC];
	assign memPtrReset  = domRst[DOM_MEMPTR];
	assign pciCfgReset  = domRst[DOM_PCICFG];
	assign phyCfgReset  = domRst[DOM_PHY];
	assign pmEventReset = domRst[DOM_PMEVT];
	assign statCntReset = domRst[DOM_STAT];
	// eeprom load begins when its reset releases
	assign eepromLoadStart = eepromPrev && !domRst[DOM_EEPROM];

	////////////////////////////////////////////////////////////////////////
	// management bus interaction

	// host resets are never held off by a running mgmt cycle
	wire next_abort = fullEv ? 1'b0 :
		!mgmtCycleActive ? 1'b0 :
		(abortEv || mgmtAbort);

	wire next_status = (fullEv || d3ToD0) ? 1'b0 :
		(mgmtStatusSetReq || mgmtStatusActive);
	wire next_rxEn = (fullEv || d3ToD0) ? 1'b0 :
		(mgmtRxEnableReq || mgmtRxEnable);
	// set wins over acknowledge
	wire next_init = initEv || (initStatusBit && !mgmtAlertAck);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mgmtTerminate    <= 1'b0;
			mgmtAbort        <= 1'b0;
			mgmtStatusActive <= 1'b0;
			mgmtRxEnable     <= 1'b0;
			initStatusBit    <= 1'b0;
			mgmtReadData     <= ZERO_BYTE;
		end else begin
			mgmtTerminate    <= fullEv;
			mgmtAbort        <= next_abort;
			mgmtStatusActive <= next_status;
			mgmtRxEnable     <= next_rxEn;
			initStatusBit    <= next_init;
			mgmtReadData     <= (next_abort || !mgmtCycleRead) ?
				ZERO_BYTE : mgmtRawData;
		end
	end

	assign mgmtWriteIgnore     = mgmtAbort;
	assign mgmt_bus_alert_n_o  = 1'b0;
	assign mgmt_bus_alert_n_oe = initStatusBit;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_ALT_ALL: assert property (
		altEv |=> domRst == EFF_ALT)
		else $error("alternate reset missed a domain");

	AST_SEL_ONLY: assert property (
		selResetCmd && !fullEv && !d3ToD0 && !swResetCmd
		|=> domRst == EFF_SEL)
		else $error("selective reset wrong domains");

	AST_SW_DOMS: assert property (
		swResetCmd && !fullEv && !d3ToD0
		|=> domRst == EFF_SW && !pciCfgReset)
		else $error("software reset wrong domains");

	AST_ISO_HELD: assert property (
		!isoSync[1] && !isoPrev && !altEv && !hostEv && !abortEv
		|=> domRst == EFF_NONE)
		else $error("isolation acted while held");

	AST_ISO_EDGE: assert property (
		isoEv && !altEv && !hostEv && !abortEv
		|=> domRst == EFF_ISO ##1 eepromLoadStart)
		else $error("isolation release effect wrong");

	AST_PM_AUX: assert property (
		hostEv && auxSync[1] && !altEv |=> !pmEventReset)
		else $error("pm state cleared with aux power");

	AST_HOST_D3: assert property (
		pmInD3 && hostLow && !altEv && !isoEv && !abortEv
		|=> domRst == EFF_NONE)
		else $error("host reset acted during D3 hold");

	AST_FULL_MGMT: assert property (
		fullEv |=> mgmtTerminate && !mgmtStatusActive && !mgmtRxEnable)
		else $error("mgmt not terminated by full reset");

	AST_D3_ABORT: assert property (
		d3ToD0 && mgmtCycleActive && !fullEv
		|=> mgmtAbort && mgmtReadData == ZERO_BYTE && !mgmtStatusActive)
		else $error("D3-D0 abort wrong");

	AST_ALERT: assert property (
		initEv |=> initStatusBit && mgmt_bus_alert_n_oe)
		else $error("alert not raised after init");

	AST_SW_KEEP: assert property (
		(swResetCmd || selResetCmd) && !fullEv && !d3ToD0
		&& !mgmtStatusSetReq |=> $stable(mgmtStatusActive))
		else $error("software reset changed mgmt status");

	AST_PHY_FULL_ONLY: assert property (
		!altEv && !hostEv |=> !phyCfgReset)
		else $error("phy reset from a minor source");

	AST_INIT_HOLD: assert property (
		initStatusBit && !mgmtAlertAck |=> initStatusBit)
		else $error("init status dropped without ack");

endmodule : reset_init_distributor

// ---- test/mgmt_partner.sv ----
`timescale 1ns/1ps
module mgmt_partner (
	// clock
	input  wire logic       ref_clk,
	// host reset and controller side
	output logic            hostBusReset_n,
	output logic            mgmtCycleActive,
	output logic            mgmtCycleRead,
	output logic [7:0]      mgmtRawData,
	output logic            mgmtStatusSetReq,
	output logic            mgmtRxEnableReq,
	output logic            mgmtAlertAck
);
	initial begin
		hostBusReset_n = 1'b1;
		mgmtCycleActive = 1'b0;
		mgmtCycleRead = 1'b0;
		mgmtRawData = 8'h3C;
		mgmtStatusSetReq = 1'b0;
		mgmtRxEnableReq = 1'b0;
		mgmtAlertAck = 1'b0;
	end
	task automatic bus_cycle(input logic on, input logic [7:0] d);
		@(negedge ref_clk);
		mgmtCycleActive = on;
		mgmtCycleRead = on;
		// idle data shows inverse of the last value
		mgmtRawData = on ? d : ~mgmtRawData;
	endtask : bus_cycle
	task automatic ctl(input logic s, input logic a);
		@(negedge ref_clk);
		mgmtStatusSetReq = s;
		mgmtRxEnableReq = s;
		mgmtAlertAck = a;
		@(negedge ref_clk);
		mgmtStatusSetReq = 1'b0;
		mgmtRxEnableReq = 1'b0;
		mgmtAlertAck = 1'b0;
	endtask : ctl
	task automatic host_level(input logic lvl);
		hostBusReset_n = lvl;
	endtask : host_level
endmodule : mgmt_partner

// ---- test/reset_init_distributor_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("ERROR %0t: got %h want %h", $time, a, e); end end
module reset_init_distributor_tb_top;
	logic ref_clk = 0, rst_b = 0, altN = 1, isoN = 1, aux = 0, inD3 = 0;
	logic d30 = 0, sw = 0, sel = 0, ld, term;
	logic hostN, cyc, rd, sReq, rReq, ack, wIgn, abrt, stat, rxEn, initB;
	logic alO, alOe, eLd, uc, mac, mem, pci, phy, pm, st;
	logic [7:0] raw, rdat;
	logic [6:0] seen;
	int num_errors = 0, tests_run = 0, cycles = 0;
	wire logic [6:0] dom = {st, pm, phy, pci, mem, mac, uc};
	always #2.5 ref_clk = ~ref_clk;
	mgmt_partner u_far (.ref_clk(ref_clk), .hostBusReset_n(hostN),
		.mgmtCycleActive(cyc), .mgmtCycleRead(rd), .mgmtRawData(raw),
		.mgmtStatusSetReq(sReq), .mgmtRxEnableReq(rReq), .mgmtAlertAck(ack));
	reset_init_distributor u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.alternate_reset_n(altN), .hostBusReset_n(hostN),
		.bus_isolation_n(isoN), .auxPowerPresent(aux), .pmInD3(inD3),
		.d3ToD0(d30), .swResetCmd(sw), .selResetCmd(sel),
		.mgmtCycleActive(cyc), .mgmtCycleRead(rd), .mgmtRawData(raw),
		.mgmtStatusSetReq(sReq), .mgmtRxEnableReq(rReq),
		.mgmtAlertAck(ack), .mgmtReadData(rdat), .mgmtWriteIgnore(wIgn),
		.mgmtTerminate(term), .mgmtAbort(abrt), .mgmtStatusActive(stat),
		.mgmtRxEnable(rxEn), .initStatusBit(initB),
		.mgmt_bus_alert_n_o(alO), .mgmt_bus_alert_n_oe(alOe),
		.eepromLoadStart(eLd), .ucodeReset(uc), .macCfgReset(mac),
		.memPtrReset(mem), .pciCfgReset(pci), .phyCfgReset(phy),
		.pmEventReset(pm), .statCntReset(st));
	////////////////////////////////////////////////////////////////////////
	task automatic watch(input int n);
		seen = dom;
		ld = eLd;
		repeat (n) begin
			@(negedge ref_clk);
			seen |= dom;
			ld |= eLd;
		end
	endtask : watch
	task automatic pulses;
		logic [6:0] exp [3] = '{7'h4F, 7'h47, 7'h04};
		for (int k = 0; k < 3; k++) begin
			d30 = (k == 0);
			sw = (k == 1);
			sel = (k == 2);
			@(negedge ref_clk);
			{d30, sw, sel} = '0;
			watch(4);
			`CHK(seen, exp[k])
			`CHK(ld, 1'b0)
		end
		$display("test pulses done");
	endtask : pulses
	task automatic held_edges;
		isoN = 0;
		watch(6);
		`CHK(seen, 7'h00)
		isoN = 1;
		watch(8);
		`CHK(seen, 7'h0A)
		`CHK(ld, 1'b1)
		inD3 = 1;
		u_far.host_level(0);
		watch(6);
		`CHK(seen, 7'h00)
		u_far.host_level(1);
		watch(8);
		`CHK(seen, 7'h7F)
		inD3 = 0;
		aux = 1;
		u_far.host_level(0);
		watch(6);
		`CHK(seen, 7'h5F)
		u_far.host_level(1);
		watch(8);
		`CHK(seen, 7'h5F)
		$display("test held_edges done");
	endtask : held_edges
	task automatic mgmt;
		u_far.ctl(1, 0);
		u_far.bus_cycle(1, 8'hA5);
		watch(3);
		`CHK(rdat, 8'hA5)
		d30 = 1;
		@(negedge ref_clk);
		d30 = 0;
		`CHK(({abrt, wIgn, rdat, stat, rxEn}), 12'hC00)
		`CHK(({initB, alOe, alO}), 3'b110)
		u_far.ctl(1, 1);
		`CHK(({initB, alOe, stat}), 3'b001)
		u_far.bus_cycle(0, 8'h00);
		u_far.bus_cycle(1, 8'h96);
		sw = 1;
		@(negedge ref_clk);
		sw = 0;
		`CHK(({abrt, rdat, stat, rxEn, initB}), 12'h807)
		u_far.bus_cycle(0, 8'h00);
		watch(2);
		`CHK(abrt, 1'b0)
		u_far.ctl(0, 1);
		u_far.bus_cycle(1, 8'hC3);
		sel = 1;
		@(negedge ref_clk);
		sel = 0;
		`CHK(({abrt, rdat, stat, rxEn, initB}), 12'h806)
		u_far.host_level(0);
		watch(6);
		`CHK(({seen, stat, rxEn, abrt, term}), 11'h5F1)
		u_far.host_level(1);
		watch(8);
		u_far.bus_cycle(0, 8'h00);
		u_far.ctl(1, 0);
		altN = 0;
		watch(6);
		`CHK(({seen, stat, rxEn, abrt, term}), 11'h7F1)
		altN = 1;
		watch(8);
		`CHK(ld, 1'b1)
		$display("test mgmt done");
	endtask : mgmt
	task automatic complete_run;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		rst_b = 1;
		watch(8);
		pulses();
		held_edges();
		mgmt();
		complete_run();
	end
endmodule : reset_init_distributor_tb_top
